// File: inc/pih_pkg.sv
// Package for the port input handshake controller.
// Assumes a single 100 MHz clock domain and an APB register slave.
package pih_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] PIH_OFS_CTRL   = 12'h000;
  localparam logic [11:0] PIH_OFS_CFG_HI = 12'h004;
  localparam logic [11:0] PIH_OFS_CFG_MD = 12'h008;
  localparam logic [11:0] PIH_OFS_CFG_LO = 12'h00C;
  localparam logic [11:0] PIH_OFS_DATA   = 12'h010;
  localparam logic [11:0] PIH_OFS_STAT   = 12'h014;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int PIH_CTRL_MODE_LSB = 0;
  localparam int PIH_CTRL_MODE_W   = 2;
  localparam int PIH_CTRL_DMA_EN   = 2;
  localparam int PIH_CTRL_DMA_CH   = 3;
  localparam int PIH_CTRL_DIR      = 4;
  localparam int PIH_CTRL_EVT_STB  = 5;

  // Status register fields
  localparam int PIH_STAT_READY    = 0;
  localparam int PIH_STAT_STB_LVL  = 1;
  localparam int PIH_STAT_TAKE_LVL = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PIH_RST_CFG_HI = 8'hFF;
  localparam logic [7:0] PIH_RST_CFG_MD = 8'h00;
  localparam logic [7:0] PIH_RST_CFG_LO = 8'h00;
  localparam logic [5:0] PIH_RST_CTRL   = 6'h00;

  // ---------------------------------------------------------------
  // Handshake modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PIH_MODE_OFF      = 2'b00,
    PIH_MODE_ONE_LINE = 2'b01,
    PIH_MODE_TWO_LINE = 2'b10
  } pih_mode_t;

  // Two-line handshake states
  typedef enum logic [1:0] {
    PIH_ST_IDLE  = 2'b00,
    PIH_ST_OPEN  = 2'b01,
    PIH_ST_FULL  = 2'b10
  } pih_state_t;

endpackage

// File: src/pih_ctrl.sv
// Port input handshake controller: strobes, ready lines, input latches,
// alternate-function output merging and timer DMA hooks.
// Assumes an APB master on the core side; strobes synchronous to clock after sync.
`timescale 1ns/1ns
`default_nettype none

module pih_ctrl
  import pih_pkg::*;
#(
  parameter int WIDTH = 8
)(
  input  wire logic             clock,
  input  wire logic             rstn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Port pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  output logic      [WIDTH-1:0] out_latch,
  // Handshake lines
  input  wire logic             in_load_strobe,
  input  wire logic             out_taken_strobe,
  output logic                  in_latch_ready,
  output logic                  out_data_ready,
  // Other alternate outputs sharing the ready pins (1 when disabled)
  input  wire logic             other_af_in_rdy,
  input  wire logic             other_af_out_rdy,
  output logic                  in_rdy_pin,
  output logic                  out_rdy_pin,
  // External interrupt channel feeds
  output logic                  irq_in_load,
  output logic                  irq_out_taken,
  // Timer link
  output logic                  transfer_direction,
  input  wire logic             compare_sync,
  input  wire logic             capture_sync,
  input  wire logic             timer_event,
  output logic                  dma_port_read,
  output logic                  dma_port_write
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [5:0]       ctrl_reg;
  logic [WIDTH-1:0] cfg_hi_reg;
  logic [WIDTH-1:0] cfg_md_reg;
  logic [WIDTH-1:0] cfg_lo_reg;
  logic [WIDTH-1:0] master_reg;
  logic [WIDTH-1:0] latch_reg;
  logic             ready_reg;
  pih_state_t       state_reg;
  pih_mode_t        mode;

  logic [1:0] ld_sync_reg;
  logic [1:0] tk_sync_reg;
  logic       ld_prev_reg;
  logic       tk_prev_reg;
  logic       ld_rise;
  logic       tk_rise;

  logic apb_wr;
  logic apb_rd;
  logic core_rd;
  logic dma_rd;
  logic dma_wr;
  logic port_read;
  logic dma_on;
  logic evt_strobe;

  logic [WIDTH-1:0] is_af;
  logic [WIDTH-1:0] is_in;
  logic [WIDTH-1:0] is_bid;
  logic [WIDTH-1:0] hs_bits;
  logic [WIDTH-1:0] sample_en;

  assign mode    = pih_mode_t'(ctrl_reg[PIH_CTRL_MODE_LSB +: PIH_CTRL_MODE_W]);
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & penable & ~pwrite;
  assign core_rd = apb_rd & (paddr == PIH_OFS_DATA);

  // ---------------------------------------------------------------
  // DMA hooks on the timer channels
  // ---------------------------------------------------------------
  assign dma_on = ctrl_reg[PIH_CTRL_DMA_EN];
  // Compare channel only moves data outwards
  assign transfer_direction = ctrl_reg[PIH_CTRL_DIR] & ~ctrl_reg[PIH_CTRL_DMA_CH];
  assign dma_rd = dma_on & ~ctrl_reg[PIH_CTRL_DMA_CH] & ctrl_reg[PIH_CTRL_DIR]
                  & capture_sync;
  assign dma_wr = dma_on & ((~ctrl_reg[PIH_CTRL_DMA_CH] & ~ctrl_reg[PIH_CTRL_DIR]
                  & capture_sync) | (ctrl_reg[PIH_CTRL_DMA_CH] & compare_sync));
  assign dma_port_read  = dma_rd;
  assign dma_port_write = dma_wr;
  assign port_read = core_rd | dma_rd;
  assign evt_strobe = (mode == PIH_MODE_OFF) & ctrl_reg[PIH_CTRL_EVT_STB] & timer_event;

  // ---------------------------------------------------------------
  // Strobe synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ld_sync_reg <= 2'b11;
      tk_sync_reg <= 2'b11;
      ld_prev_reg <= 1'b1;
      tk_prev_reg <= 1'b1;
    end
    else
    begin
      // Strobes come straight from the pin input buffer
      ld_sync_reg <= {ld_sync_reg[0], in_load_strobe};
      tk_sync_reg <= {tk_sync_reg[0], out_taken_strobe};
      ld_prev_reg <= ld_sync_reg[1];
      tk_prev_reg <= tk_sync_reg[1];
    end
  end

  assign ld_rise = ld_sync_reg[1] & ~ld_prev_reg;
  assign tk_rise = tk_sync_reg[1] & ~tk_prev_reg;
  assign irq_in_load   = ld_rise;
  assign irq_out_taken = tk_rise;

  // ---------------------------------------------------------------
  // Per-bit configuration decode
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      // Alternate output when mid and lo are set, hi is don't care
      assign is_af[gi]  = cfg_md_reg[gi] & cfg_lo_reg[gi];
      assign is_in[gi]  = ~cfg_md_reg[gi] & cfg_lo_reg[gi];
      assign is_bid[gi] = ~cfg_md_reg[gi] & ~cfg_lo_reg[gi];
      assign hs_bits[gi] = is_in[gi] | is_bid[gi];
      assign pin_out[gi] = master_reg[gi];
      assign pin_oe_n[gi] = is_in[gi] | is_af[gi];
    end
  endgenerate
  assign out_latch = master_reg;

  // ---------------------------------------------------------------
  // Handshake state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg     <= PIH_ST_IDLE;
    end
    else
    begin
      case (state_reg)
        PIH_ST_IDLE:
        begin
          if (mode == PIH_MODE_TWO_LINE && ld_rise)
            state_reg <= PIH_ST_FULL;
          else if (mode == PIH_MODE_TWO_LINE)
            state_reg <= PIH_ST_OPEN;
        end
        PIH_ST_OPEN:
        begin
          if (mode != PIH_MODE_TWO_LINE)
            state_reg <= PIH_ST_IDLE;
          else if (ld_rise)
            state_reg <= PIH_ST_FULL;
        end
        PIH_ST_FULL:
        begin
          if (mode != PIH_MODE_TWO_LINE)
            state_reg <= PIH_ST_IDLE;
          else if (port_read)
            state_reg <= PIH_ST_OPEN;
        end
        default: state_reg <= PIH_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Input-ready line
  // ---------------------------------------------------------------
  always_comb
  begin
    case (mode)
      PIH_MODE_TWO_LINE: ready_reg = (state_reg != PIH_ST_FULL);
      PIH_MODE_ONE_LINE: ready_reg = ~core_rd & ~dma_rd;
      default:           ready_reg = 1'b1;
    endcase
  end
  assign in_latch_ready = ready_reg;
  assign out_data_ready = 1'b1;
  // Disabled alternate outputs give 1, so AND merges them
  assign in_rdy_pin  = in_latch_ready & other_af_in_rdy;
  assign out_rdy_pin = out_data_ready & other_af_out_rdy;

  // ---------------------------------------------------------------
  // Input latch load enables
  // ---------------------------------------------------------------
  always_comb
  begin
    case (mode)
      PIH_MODE_TWO_LINE:
        sample_en = (state_reg == PIH_ST_OPEN && !ld_sync_reg[1])
                    ? hs_bits : '0;
      PIH_MODE_ONE_LINE:
        sample_en = (core_rd | dma_rd) ? '0 : hs_bits;
      default:
        sample_en = (ctrl_reg[PIH_CTRL_EVT_STB] && !evt_strobe) ? '0 : '1;
    endcase
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      latch_reg <= '1;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (mode != PIH_MODE_OFF && !hs_bits[i])
          latch_reg[i] <= is_af[i] ? pin_in[i] : master_reg[i];
        else if (sample_en[i])
          latch_reg[i] <= pin_in[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // APB register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg   <= PIH_RST_CTRL;
      cfg_hi_reg <= WIDTH'(PIH_RST_CFG_HI);
      cfg_md_reg <= WIDTH'(PIH_RST_CFG_MD);
      cfg_lo_reg <= WIDTH'(PIH_RST_CFG_LO);
      master_reg <= '1;
    end
    else
    begin
      if (apb_wr)
      begin
        case (paddr)
          PIH_OFS_CTRL:   ctrl_reg   <= pwdata[5:0];
          PIH_OFS_CFG_HI: cfg_hi_reg <= pwdata[WIDTH-1:0];
          PIH_OFS_CFG_MD: cfg_md_reg <= pwdata[WIDTH-1:0];
          PIH_OFS_CFG_LO: cfg_lo_reg <= pwdata[WIDTH-1:0];
          PIH_OFS_DATA:   master_reg <= pwdata[WIDTH-1:0];
          default:        ;
        endcase
      end
      else if (dma_wr)
        master_reg <= pwdata[WIDTH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // APB read data and answer
  // ---------------------------------------------------------------
  logic addr_ok;
  assign addr_ok = (paddr == PIH_OFS_CTRL) || (paddr == PIH_OFS_CFG_HI) ||
                   (paddr == PIH_OFS_CFG_MD) || (paddr == PIH_OFS_CFG_LO) ||
                   (paddr == PIH_OFS_DATA) || (paddr == PIH_OFS_STAT);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      case (paddr)
        PIH_OFS_CTRL:   prdata[5:0]       <= ctrl_reg;
        PIH_OFS_CFG_HI: prdata[WIDTH-1:0] <= cfg_hi_reg;
        PIH_OFS_CFG_MD: prdata[WIDTH-1:0] <= cfg_md_reg;
        PIH_OFS_CFG_LO: prdata[WIDTH-1:0] <= cfg_lo_reg;
        PIH_OFS_DATA:   prdata[WIDTH-1:0] <= latch_reg;
        PIH_OFS_STAT:
        begin
          prdata[PIH_STAT_READY]    <= in_latch_ready;
          prdata[PIH_STAT_STB_LVL]  <= ld_sync_reg[1];
          prdata[PIH_STAT_TAKE_LVL] <= tk_sync_reg[1];
        end
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

endmodule

`default_nettype wire

// File: test/pih_ctrl_props.sv
// Checker for the input handshake ports of pih_ctrl.
// Assumes a bind to every pih_ctrl instance; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module pih_ctrl_props
  import pih_pkg::*;
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        in_load_strobe,
  input wire logic        in_latch_ready,
  input wire logic        out_data_ready,
  input wire logic        other_af_in_rdy,
  input wire logic        other_af_out_rdy,
  input wire logic        in_rdy_pin,
  input wire logic        out_rdy_pin,
  input wire logic        irq_in_load,
  input wire logic        dma_port_read
);
  logic [1:0] mode_reg;
  logic       rd_data;
  logic       ctl_wr;
  assign rd_data = (psel && penable && !pwrite && paddr == PIH_OFS_DATA) || dma_port_read;
  assign ctl_wr  = psel && penable && pwrite && paddr == PIH_OFS_CTRL;
  // Mode mirror, updated at the access edge of a control write
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      mode_reg <= 2'h0;
    else if (ctl_wr)
      mode_reg <= pwdata[1:0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_in_pin_and: assert property (in_rdy_pin == (in_latch_ready & other_af_in_rdy))
    else $error("input ready pin is not the AND of its sources");
  chk_out_pin_and: assert property (out_rdy_pin == (out_data_ready & other_af_out_rdy))
    else $error("output ready pin is not the AND of its sources");
  chk_out_rdy_idle: assert property (out_data_ready)
    else $error("idle output ready not high");
  chk_off_rdy_high: assert property (mode_reg == 2'h0 |-> in_latch_ready)
    else $error("input ready low with handshake off");
  chk_one_line_rdy: assert property (mode_reg == 2'h1 |-> in_latch_ready == !rd_data)
    else $error("one-line ready not low exactly during a port read");
  chk_two_drop: assert property (mode_reg == 2'h2 && irq_in_load && !rd_data && !ctl_wr
    |=> !in_latch_ready)
    else $error("ready did not fall after a load strobe edge");
  chk_two_block: assert property (mode_reg == 2'h2 && !in_latch_ready && !rd_data && !ctl_wr
    |=> !in_latch_ready)
    else $error("ready rose without a port read");
  chk_two_reopen: assert property (mode_reg == 2'h2 && rd_data |=> in_latch_ready)
    else $error("ready not set after a port read");
  chk_irq_follow: assert property ($rose(in_load_strobe) |-> ##[1:4] irq_in_load)
    else $error("no interrupt pulse after a strobe rise");
  chk_irq_pulse: assert property (irq_in_load |=> !irq_in_load)
    else $error("interrupt pulse longer than one cycle");
endmodule
bind pih_ctrl pih_ctrl_props i_pih_ctrl_props (
  .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .in_load_strobe(in_load_strobe),
  .in_latch_ready(in_latch_ready), .out_data_ready(out_data_ready),
  .other_af_in_rdy(other_af_in_rdy), .other_af_out_rdy(other_af_out_rdy),
  .in_rdy_pin(in_rdy_pin), .out_rdy_pin(out_rdy_pin), .irq_in_load(irq_in_load),
  .dma_port_read(dma_port_read));
`default_nettype wire

// File: test/pih_periph.sv
// Model of the peripheral that feeds parallel words and strobes.
// Assumes the bench calls its tasks; strobes idle high.
`timescale 1ns/1ns
`default_nettype none
module pih_periph
(
  input  wire logic       clock,
  output logic      [7:0] pin_in,
  output logic            in_load_strobe,
  output logic            out_taken_strobe
);
  initial
  begin
    pin_in = 8'h00;
    in_load_strobe = 1'b1;
    out_taken_strobe = 1'b1;
  end
  // Word held while strobe is low and through the sync delay, then released
  task automatic send(input logic [7:0] d);
    @(posedge clock);
    pin_in <= d;
    in_load_strobe <= 1'b0;
    repeat (2) @(posedge clock);
    in_load_strobe <= 1'b1;
    repeat (4) @(posedge clock);
    pin_in <= ~d;
    repeat (2) @(posedge clock);
  endtask
  // Word presented without strobe; taken while ready is high in one-line mode
  task automatic put(input logic [7:0] d);
    @(posedge clock);
    pin_in <= d;
  endtask
  task automatic take();
    @(posedge clock);
    out_taken_strobe <= 1'b0;
    repeat (2) @(posedge clock);
    out_taken_strobe <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: test/pih_ctrl_tb.sv
// Self-checking bench for pih_ctrl over APB with a peripheral model.
// Assumes zero-wait APB and the package offsets.
`timescale 1ns/1ns
`default_nettype none
module pih_ctrl_tb
  import pih_pkg::*;
;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  pin_in;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe_n;
  logic [7:0]  out_latch;
  logic        in_load_strobe;
  logic        out_taken_strobe;
  logic        in_latch_ready;
  logic        out_data_ready;
  logic        other_af_in_rdy = 1'b1;
  logic        other_af_out_rdy = 1'b1;
  logic        in_rdy_pin;
  logic        out_rdy_pin;
  logic        irq_in_load;
  logic        irq_out_taken;
  logic        transfer_direction;
  logic        compare_sync = 1'b0;
  logic        capture_sync = 1'b0;
  logic        timer_event = 1'b0;
  logic        dma_port_read;
  logic        dma_port_write;
  logic [31:0] r;
  logic        e;
  int          fail_count = 0;
  int          total_checks = 0;
  int          n_irq = 0;
  int          n_tk = 0;
  int          cyc = 0;
  pih_ctrl i_pih_ctrl (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .out_latch(out_latch),
    .in_load_strobe(in_load_strobe), .out_taken_strobe(out_taken_strobe),
    .in_latch_ready(in_latch_ready), .out_data_ready(out_data_ready),
    .other_af_in_rdy(other_af_in_rdy), .other_af_out_rdy(other_af_out_rdy),
    .in_rdy_pin(in_rdy_pin), .out_rdy_pin(out_rdy_pin), .irq_in_load(irq_in_load),
    .irq_out_taken(irq_out_taken), .transfer_direction(transfer_direction),
    .compare_sync(compare_sync), .capture_sync(capture_sync), .timer_event(timer_event),
    .dma_port_read(dma_port_read), .dma_port_write(dma_port_write));
  pih_periph i_pih_periph (.clock(clock), .pin_in(pin_in),
    .in_load_strobe(in_load_strobe), .out_taken_strobe(out_taken_strobe));
  always #5 clock = ~clock;
  // Pulse counting and hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (irq_in_load === 1'b1)
      n_irq++;
    if (irq_out_taken === 1'b1)
      n_tk++;
    if (cyc == 3000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rdy(input logic v);
    int n;
    n = 0;
    while (in_latch_ready !== v && n < 10)
    begin
      @(posedge clock);
      n++;
    end
    #1;
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1 chk("ready", 1, in_latch_ready);
    apb(1'b0, PIH_OFS_CFG_HI, 0);
    chk("cfg_hi", 32'hFF, r);
    apb(1'b0, PIH_OFS_CTRL, 0);
    chk("ctrl", 32'h0, r);
    apb(1'b0, 12'h018, 0);
    chk("unmapped", 32'h0, r);
    chk("slverr", 1, e);
    apb(1'b1, PIH_OFS_CFG_MD, 32'h80);
    apb(1'b1, PIH_OFS_CFG_LO, 32'h01);
    #1 chk("oe_n", 32'h01, pin_oe_n);
    apb(1'b1, PIH_OFS_DATA, 32'hA5);
    #1 chk("pin_out", 32'hA5, pin_out);
    chk("out_latch", 32'hA5, out_latch);
    apb(1'b1, PIH_OFS_CTRL, 32'h2);
    #1 chk("ready", 1, in_latch_ready);
    @(posedge clock);
    other_af_in_rdy <= 1'b0;
    #1 chk("rdy_pin", 0, in_rdy_pin);
    @(posedge clock);
    other_af_in_rdy <= 1'b1;
    i_pih_periph.send(8'h3C);
    wait_rdy(1'b0);
    chk("ready", 0, in_latch_ready);
    i_pih_periph.send(8'h5A);
    chk("ready", 0, in_latch_ready);
    apb(1'b0, PIH_OFS_STAT, 0);
    chk("stat", 32'h6, r);
    apb(1'b0, PIH_OFS_DATA, 0);
    chk("data", 32'hBC, r);
    #1 chk("ready", 1, in_latch_ready);
    chk("irqs", 2, n_irq);
    apb(1'b1, PIH_OFS_CTRL, 32'h1);
    #1 chk("ready", 1, in_latch_ready);
    i_pih_periph.put(8'h66);
    repeat (3) @(posedge clock);
    apb(1'b0, PIH_OFS_DATA, 0);
    chk("data", 32'hE6, r);
    #1 chk("ready", 1, in_latch_ready);
    apb(1'b1, PIH_OFS_CTRL, 32'h0);
    #1 chk("ready", 1, in_latch_ready);
    i_pih_periph.send(8'h11);
    i_pih_periph.take();
    repeat (4) @(posedge clock);
    chk("irqs", 3, n_irq);
    chk("taken_irqs", 1, n_tk);
    apb(1'b1, PIH_OFS_CTRL, 32'h20);
    i_pih_periph.put(8'h77);
    repeat (2) @(posedge clock);
    apb(1'b0, PIH_OFS_DATA, 0);
    chk("frozen", 32'hEE, r);
    timer_event <= 1'b1;
    @(posedge clock);
    timer_event <= 1'b0;
    apb(1'b0, PIH_OFS_DATA, 0);
    chk("evt_data", 32'h77, r);
    apb(1'b1, PIH_OFS_CTRL, 32'h14);
    #1 chk("dir", 1, transfer_direction);
    @(posedge clock);
    capture_sync <= 1'b1;
    #1 chk("dma_rd", 1, dma_port_read);
    @(posedge clock);
    capture_sync <= 1'b0;
    apb(1'b1, PIH_OFS_CTRL, 32'h1C);
    #1 chk("dir", 0, transfer_direction);
    @(posedge clock);
    compare_sync <= 1'b1;
    #1 chk("dma_wr", 1, dma_port_write);
    @(posedge clock);
    compare_sync <= 1'b0;
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    #1 chk("ready", 1, in_latch_ready);
    wrap_up();
  end
endmodule
`default_nettype wire
